// [hw/spa_pkg.sv]
//----------------------------------------------------------------------
// Purpose: shared constants and types of the serial port core
// Assumes: 32-bit register port, one word per register
// Notes:   control fields keep their documented bit positions
//----------------------------------------------------------------------
package spa_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] OFF_CTRL_LOW = 4'h0;
    localparam logic [3:0] OFF_CTRL_HIGH = 4'h4;
    localparam logic [3:0] OFF_DATA = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hc;

    // ------------------------------------------------------------
    // serial_control_low fields
    // ------------------------------------------------------------
    localparam int BIT_MODULE_ON = 15;
    localparam int BIT_IDLE_HALT = 13;
    localparam int BIT_OUT_REL = 12;
    localparam int BIT_WORD_LONG = 11;
    localparam int BIT_WORD_MID = 10;
    localparam int BIT_SAMPLE_PHASE = 9;
    localparam int BIT_CLOCK_EDGE = 8;
    localparam int BIT_SEL_IN_EN = 7;
    localparam int BIT_CLOCK_POL = 6;
    localparam int BIT_MASTER = 5;
    localparam int BIT_IN_REL = 4;
    localparam int BIT_CLK_REL = 3;
    localparam int BIT_BAUD_SRC = 2;
    localparam int BIT_FRAME_EDGE = 1;
    localparam int BIT_FIFO_MODE = 0;
    localparam logic [15:0] CTRL_LOW_MASK = 16'hbfff;
    localparam logic [15:0] CTRL_LOW_RESET = 16'h0000;

    // ------------------------------------------------------------
    // control high and status fields
    // ------------------------------------------------------------
    localparam int BIT_AUDIO = 15;
    localparam int BIT_FRAMING = 7;
    localparam logic [15:0] CTRL_HIGH_MASK = 16'h8080;
    localparam logic [15:0] CTRL_HIGH_RESET = 16'h0000;
    localparam int ST_RX_FULL = 0;
    localparam int ST_TX_FULL = 1;
    localparam int ST_TX_EMPTY = 3;
    localparam int ST_RX_EMPTY = 5;
    localparam int ST_RX_OVF = 6;
    localparam int ST_BUSY = 11;

    // ------------------------------------------------------------
    // word lengths, fifo depths, baud
    // ------------------------------------------------------------
    localparam logic [5:0] W8 = 6'h08;
    localparam logic [5:0] W16 = 6'h10;
    localparam logic [5:0] W24 = 6'h18;
    localparam logic [5:0] W32 = 6'h20;
    localparam logic [5:0] DEPTH_STD = 6'h01;
    localparam logic [5:0] DEPTH_W32 = 6'h08;
    localparam logic [5:0] DEPTH_W16 = 6'h10;
    localparam logic [5:0] DEPTH_W8 = 6'h20;
    localparam int FIFO_ENTRIES = 32;
    localparam int FIFO_AW = 5;
    localparam logic [7:0] BAUD_HALF_TICKS = 8'h04;

    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_WAIT_LRC,
        ENG_SHIFT
    } spa_eng_state_t;

endpackage

// [hw/spa_serial_core.sv]
//----------------------------------------------------------------------
// Purpose: serial port core, slave, master and audio clocking
// Assumes: pins are sampled by clk through two flip-flops
// Notes:   framing counters, underrun policy and interrupts left out
//----------------------------------------------------------------------
// Overview of operation
// - select enabled: shift only while select low
// - select high aborts word, resend later
// - select disabled: select pin ignored
// - select off: empty flag sets at load
// - select on: empty flag sets after send
// - slave shifts only on master clock edges
// - fifo depth 8/16/32 by word length
// - audio master clocks run while enabled
// - audio master starts clocks within one period
// - audio slave sends zeros until left edge
// - audio slave then shifts continuously
// - module off resets and stops everything but the overflow flag
// - idle halt bit freezes during idle
// - output release frees serial output pin
// - word length 32/16/8 without audio
// - audio word and channel length table
// - master sample phase middle or end
// - slave always samples at middle
// - audio forces clock edge select zero
// - framing ignores select input enable
// - baud source writable only when off
// - clock polarity sets idle level
// - clock edge select picks launch edge
// - master select chooses master or slave
// - frame edge aligns or precedes first bit
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module spa_serial_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic cpuIdle,
    input wire logic referenceClockOut,
    input wire logic shiftClockPinIn,
    output logic shiftClockPinOut,
    output logic shiftClockPinOeN,
    input wire logic serialInPin,
    output logic serialOutPinOut,
    output logic serialOutPinOeN,
    input wire logic slaveSelectPinIn,
    output logic channelClockOut,
    output logic channelClockOeN
);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [15:0] ctrlLow_reg;
    logic [15:0] ctrlHigh_reg;
    logic rxOverflow_reg;
    logic [31:0] regRdata_reg;
    logic moduleOn, idleHalt, outRel, inRel, clkRel, baudSrc, frameEdge, fifoMode;
    logic masterMode, clockPol, audio, framing, run, ckeEff, smpEnd, ssenEff;
    logic [5:0] dataBits, chanBits, depthLim;

    assign moduleOn = ctrlLow_reg[spa_pkg::BIT_MODULE_ON];
    assign idleHalt = ctrlLow_reg[spa_pkg::BIT_IDLE_HALT];
    assign outRel = ctrlLow_reg[spa_pkg::BIT_OUT_REL];
    assign inRel = ctrlLow_reg[spa_pkg::BIT_IN_REL];
    assign clkRel = ctrlLow_reg[spa_pkg::BIT_CLK_REL];
    assign baudSrc = ctrlLow_reg[spa_pkg::BIT_BAUD_SRC];
    assign frameEdge = ctrlLow_reg[spa_pkg::BIT_FRAME_EDGE];
    assign fifoMode = ctrlLow_reg[spa_pkg::BIT_FIFO_MODE];
    assign masterMode = ctrlLow_reg[spa_pkg::BIT_MASTER];
    assign clockPol = ctrlLow_reg[spa_pkg::BIT_CLOCK_POL];
    assign audio = ctrlHigh_reg[spa_pkg::BIT_AUDIO];
    assign framing = ctrlHigh_reg[spa_pkg::BIT_FRAMING];
    assign run = moduleOn && !(idleHalt && cpuIdle);
    assign ckeEff = ctrlLow_reg[spa_pkg::BIT_CLOCK_EDGE] && !audio;
    // slave always samples mid-bit, audio forces middle too
    assign smpEnd = ctrlLow_reg[spa_pkg::BIT_SAMPLE_PHASE] && masterMode && !audio;
    // audio behaves as framed, so select input enable is unused there
    assign ssenEff = ctrlLow_reg[spa_pkg::BIT_SEL_IN_EN] && !framing && !audio
                     && !masterMode;

    // ------------------------------------------------------------
    // word, channel and fifo sizing
    // ------------------------------------------------------------
    always_comb begin
        if (audio) begin
            case ({ctrlLow_reg[spa_pkg::BIT_WORD_LONG], ctrlLow_reg[spa_pkg::BIT_WORD_MID]})
                2'b11: begin dataBits = spa_pkg::W24; chanBits = spa_pkg::W32; end
                2'b10: begin dataBits = spa_pkg::W32; chanBits = spa_pkg::W32; end
                2'b01: begin dataBits = spa_pkg::W16; chanBits = spa_pkg::W32; end
                default: begin dataBits = spa_pkg::W16; chanBits = spa_pkg::W16; end
            endcase
        end else begin
            if (ctrlLow_reg[spa_pkg::BIT_WORD_LONG]) begin
                dataBits = spa_pkg::W32;
            end else if (ctrlLow_reg[spa_pkg::BIT_WORD_MID]) begin
                dataBits = spa_pkg::W16;
            end else begin
                dataBits = spa_pkg::W8;
            end
            chanBits = dataBits;
        end
        if (!fifoMode) begin
            depthLim = spa_pkg::DEPTH_STD;
        end else if (dataBits > spa_pkg::W16) begin
            depthLim = spa_pkg::DEPTH_W32;
        end else if (dataBits == spa_pkg::W16) begin
            depthLim = spa_pkg::DEPTH_W16;
        end else begin
            depthLim = spa_pkg::DEPTH_W8;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers: {ref, sdi, select, sck}
    // ------------------------------------------------------------
    logic [3:0] syncA_reg, syncB_reg;
    logic sckS, ssS, sdiS, refS;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            syncA_reg <= 4'h0;
            syncB_reg <= 4'h0;
        end else begin
            syncA_reg <= {referenceClockOut, serialInPin, slaveSelectPinIn, shiftClockPinIn};
            syncB_reg <= syncA_reg;
        end
    end
    assign {refS, sdiS, ssS, sckS} = syncB_reg;

    // ------------------------------------------------------------
    // baud divider and master clock generation
    // ------------------------------------------------------------
    logic [7:0] divCnt_reg;
    logic refPrev_reg, sckGen_reg, halfTick, tickSrc, toggleNow;
    logic [6:0] togCnt_reg, togNext;
    spa_pkg::spa_eng_state_t state_reg, stateNext;

    assign tickSrc = baudSrc ? (refS && !refPrev_reg) : 1'b1;
    assign halfTick = tickSrc && (divCnt_reg == spa_pkg::BAUD_HALF_TICKS - 8'h01);
    assign toggleNow = run && masterMode && state_reg == spa_pkg::ENG_SHIFT && halfTick
                       && (audio || togCnt_reg < {chanBits, 1'b0});

    always_ff @(posedge clk) begin
        if (!resetn || !moduleOn) begin
            divCnt_reg <= 8'h00;
            refPrev_reg <= 1'b0;
        end else begin
            refPrev_reg <= refS;
            if (halfTick) begin
                divCnt_reg <= 8'h00;
            end else if (tickSrc) begin
                divCnt_reg <= divCnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sckGen_reg <= 1'b0;
        end else if (!moduleOn) begin
            sckGen_reg <= clockPol;
        end else if (toggleNow) begin
            sckGen_reg <= !sckGen_reg;
        end
    end

    // ------------------------------------------------------------
    // edge detection on the shift clock and channel clock
    // ------------------------------------------------------------
    logic sckPrev_reg, ssPrev_reg, sckPhys, leadEdge, trailEdge;
    logic launchEdge, sampleEdge, sampleNow, pend_reg, lrcFall, ssActive, sdiEff;

    assign sckPhys = masterMode ? sckGen_reg : sckS;
    assign leadEdge = (sckPrev_reg == clockPol) && (sckPhys != clockPol);
    assign trailEdge = (sckPrev_reg != clockPol) && (sckPhys == clockPol);
    assign launchEdge = ckeEff ? trailEdge : leadEdge;
    assign sampleEdge = ckeEff ? leadEdge : trailEdge;
    assign sampleNow = smpEnd ? (pend_reg && halfTick) : sampleEdge;
    assign lrcFall = ssPrev_reg && !ssS;
    assign ssActive = !ssenEff || !ssS;
    assign sdiEff = inRel ? 1'b0 : sdiS;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sckPrev_reg <= 1'b0;
            ssPrev_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            sckPrev_reg <= sckPhys;
            ssPrev_reg <= ssS;
            if (!moduleOn) begin
                pend_reg <= 1'b0;
            end else if (run && smpEnd && sampleEdge) begin
                pend_reg <= 1'b1;
            end else if (run && halfTick) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit and receive fifos
    // ------------------------------------------------------------
    logic [31:0] txMem [spa_pkg::FIFO_ENTRIES];
    logic [31:0] rxMem [spa_pkg::FIFO_ENTRIES];
    logic [4:0] txWr_reg, txRd_reg, rxWr_reg, rxRd_reg;
    logic [5:0] txCnt_reg, rxCnt_reg;
    logic txPush, txPop, txPopEff, rxPush, rxPushEff, rxPop, rxStore, dataSel;
    logic [31:0] txHead, rxWord, loadVal;

    assign dataSel = regAddr == spa_pkg::OFF_DATA;
    assign txPush = moduleOn && regWrite && dataSel && txCnt_reg < depthLim;
    assign rxPop = moduleOn && regRead && dataSel && rxCnt_reg != 6'h00;
    assign txPopEff = run && txPop;
    assign rxPushEff = run && rxPush;
    assign rxStore = rxPushEff && rxCnt_reg < depthLim;
    assign txHead = txMem[txRd_reg];
    assign loadVal = (txCnt_reg != 6'h00) ? (txHead << (spa_pkg::W32 - dataBits)) : 32'h0;

    always_ff @(posedge clk) begin
        if (!resetn || !moduleOn) begin
            txWr_reg <= 5'h00;
            txRd_reg <= 5'h00;
            txCnt_reg <= 6'h00;
            rxWr_reg <= 5'h00;
            rxRd_reg <= 5'h00;
            rxCnt_reg <= 6'h00;
        end else begin
            if (txPush) txWr_reg <= txWr_reg + 5'h01;
            if (txPopEff) txRd_reg <= txRd_reg + 5'h01;
            txCnt_reg <= txCnt_reg + {5'h00, txPush} - {5'h00, txPopEff};
            if (rxStore) rxWr_reg <= rxWr_reg + 5'h01;
            if (rxPop) rxRd_reg <= rxRd_reg + 5'h01;
            rxCnt_reg <= rxCnt_reg + {5'h00, rxStore} - {5'h00, rxPop};
        end
    end

    always_ff @(posedge clk) begin
        if (txPush) txMem[txWr_reg] <= regWdata;
        if (rxStore) rxMem[rxWr_reg] <= rxWord;
    end

    // ------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------
    logic [31:0] shiftTx_reg, shiftRx_reg, txNext, rxNext, rxFull;
    logic [5:0] bitCnt_reg, bitNext;
    logic lrcOut_reg, lrcNext, fromFifo_reg, fromFifoNext, reload, mWordEnd;

    assign rxFull = {shiftRx_reg[30:0], sdiEff};
    assign rxWord = (rxFull >> (chanBits - dataBits)) & ~(32'hffffffff << dataBits);
    assign mWordEnd = masterMode && !audio && togCnt_reg == {chanBits, 1'b0} && !pend_reg
                      && !(smpEnd && sampleEdge);

    always_comb begin
        stateNext = state_reg;
        txNext = shiftTx_reg;
        rxNext = shiftRx_reg;
        bitNext = bitCnt_reg;
        togNext = togCnt_reg;
        lrcNext = lrcOut_reg;
        fromFifoNext = fromFifo_reg;
        txPop = 1'b0;
        rxPush = 1'b0;
        reload = 1'b0;
        if (toggleNow) togNext = togCnt_reg + 7'h01;
        case (state_reg)
            spa_pkg::ENG_IDLE: begin
                if (masterMode && (audio || txCnt_reg != 6'h00)) begin
                    stateNext = spa_pkg::ENG_SHIFT;
                    reload = 1'b1;
                end else if (!masterMode && audio) begin
                    stateNext = spa_pkg::ENG_WAIT_LRC;
                    txNext = 32'h0;
                end else if (!masterMode && ssActive) begin
                    stateNext = spa_pkg::ENG_SHIFT;
                    reload = 1'b1;
                end
            end
            spa_pkg::ENG_WAIT_LRC: begin
                if (lrcFall) begin
                    stateNext = spa_pkg::ENG_SHIFT;
                    reload = 1'b1;
                end
            end
            spa_pkg::ENG_SHIFT: begin
                if (!ssActive) begin
                    stateNext = spa_pkg::ENG_IDLE;
                    bitNext = 6'h00;
                end else begin
                    if (launchEdge && bitCnt_reg != 6'h00) begin
                        txNext = {shiftTx_reg[30:0], 1'b0};
                    end
                    // a word written while the slave clock still idles replaces the fill word
                    if (!masterMode && !audio && bitCnt_reg == 6'h00 && !fromFifo_reg
                        && txCnt_reg != 6'h00 && sckPrev_reg == clockPol && !sampleNow) begin
                        reload = 1'b1;
                    end
                    if (audio && masterMode && !frameEdge && launchEdge
                        && bitCnt_reg == chanBits - 6'h01) begin
                        lrcNext = !lrcOut_reg;
                    end
                    if (sampleNow) begin
                        rxNext = rxFull;
                        bitNext = bitCnt_reg + 6'h01;
                        if (bitCnt_reg + 6'h01 == chanBits) begin
                            bitNext = 6'h00;
                            rxPush = !inRel;
                            if (ssenEff && fromFifo_reg) txPop = 1'b1;
                            if (ssenEff) begin
                                stateNext = spa_pkg::ENG_IDLE;
                            end else if (!masterMode || audio) begin
                                reload = 1'b1;
                                if (audio && masterMode && frameEdge) begin
                                    lrcNext = !lrcOut_reg;
                                end
                            end
                        end
                    end
                    if (mWordEnd) begin
                        if (txCnt_reg != 6'h00) begin
                            reload = 1'b1;
                        end else begin
                            stateNext = spa_pkg::ENG_IDLE;
                        end
                    end
                end
            end
            default: stateNext = spa_pkg::ENG_IDLE;
        endcase
        if (reload) begin
            txNext = loadVal;
            bitNext = 6'h00;
            togNext = 7'h00;
            fromFifoNext = txCnt_reg != 6'h00;
            if (!ssenEff && txCnt_reg != 6'h00) txPop = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !moduleOn) begin
            state_reg <= spa_pkg::ENG_IDLE;
            shiftTx_reg <= 32'h0;
            shiftRx_reg <= 32'h0;
            bitCnt_reg <= 6'h00;
            togCnt_reg <= 7'h00;
            lrcOut_reg <= 1'b0;
            fromFifo_reg <= 1'b0;
        end else if (run) begin
            state_reg <= stateNext;
            shiftTx_reg <= txNext;
            shiftRx_reg <= rxNext;
            bitCnt_reg <= bitNext;
            togCnt_reg <= togNext;
            lrcOut_reg <= lrcNext;
            fromFifo_reg <= fromFifoNext;
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    logic [15:0] statusWord, ctrlLowWr;

    always_comb begin
        statusWord = 16'h0000;
        statusWord[spa_pkg::ST_RX_FULL] = rxCnt_reg == depthLim;
        statusWord[spa_pkg::ST_TX_FULL] = txCnt_reg == depthLim;
        statusWord[spa_pkg::ST_TX_EMPTY] = txCnt_reg == 6'h00;
        statusWord[spa_pkg::ST_RX_EMPTY] = rxCnt_reg == 6'h00;
        statusWord[spa_pkg::ST_RX_OVF] = rxOverflow_reg;
        statusWord[spa_pkg::ST_BUSY] = state_reg != spa_pkg::ENG_IDLE;
        ctrlLowWr = regWdata[15:0] & spa_pkg::CTRL_LOW_MASK;
        if (moduleOn) ctrlLowWr[spa_pkg::BIT_BAUD_SRC] = baudSrc;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrlLow_reg <= spa_pkg::CTRL_LOW_RESET;
            ctrlHigh_reg <= spa_pkg::CTRL_HIGH_RESET;
        end else if (regWrite) begin
            if (regAddr == spa_pkg::OFF_CTRL_LOW) ctrlLow_reg <= ctrlLowWr;
            if (regAddr == spa_pkg::OFF_CTRL_HIGH && !moduleOn) begin
                ctrlHigh_reg <= regWdata[15:0] & spa_pkg::CTRL_HIGH_MASK;
            end
        end
    end

    // overflow is sticky; a new overflow wins over a write-one clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rxOverflow_reg <= 1'b0;
        end else if (rxPushEff && !rxStore) begin
            rxOverflow_reg <= 1'b1;
        end else if (regWrite && regAddr == spa_pkg::OFF_STATUS
                     && regWdata[spa_pkg::ST_RX_OVF]) begin
            rxOverflow_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !regRead) begin
            regRdata_reg <= 32'h0;
        end else begin
            case (regAddr)
                spa_pkg::OFF_CTRL_LOW: regRdata_reg <= {16'h0000, ctrlLow_reg};
                spa_pkg::OFF_CTRL_HIGH: regRdata_reg <= {16'h0000, ctrlHigh_reg};
                spa_pkg::OFF_DATA: regRdata_reg <= (rxCnt_reg != 6'h00) ? rxMem[rxRd_reg] : 32'h0;
                spa_pkg::OFF_STATUS: regRdata_reg <= {16'h0000, statusWord};
                default: regRdata_reg <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pins, enables are active low
    // ------------------------------------------------------------
    assign regRdata = regRdata_reg;
    assign shiftClockPinOut = sckGen_reg;
    assign shiftClockPinOeN = !(moduleOn && masterMode && !clkRel);
    assign serialOutPinOut = shiftTx_reg[31];
    assign serialOutPinOeN = !(moduleOn && !outRel && ssActive);
    assign channelClockOut = lrcOut_reg;
    assign channelClockOeN = !(moduleOn && masterMode && audio);

endmodule // spa_serial_core

`default_nettype wire

// [bench/spa_serial_asserts.sv]
// Purpose: port checker of the serial core
// Assumes: audio and framing left off
// Notes: ctrl shadow follows writes
`timescale 1ns/1ps
`default_nettype none
module spa_serial_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic cpuIdle,
    input wire logic shiftClockPinOut,
    input wire logic shiftClockPinOeN,
    input wire logic serialOutPinOut,
    input wire logic serialOutPinOeN,
    input wire logic slaveSelectPinIn
);
    logic [15:0] ctrlReg;
    logic [15:0] prevReg;
    logic [2:0] selHiReg;
    wire logic st = ctrlReg == prevReg;
    wire logic on = st && ctrlReg[15];
    wire logic slv = on && !ctrlReg[5] && !ctrlReg[12];
    always_ff @(posedge clk) begin
        if (!resetn) ctrlReg <= 16'h0000;
        else if (regWrite && regAddr == 4'h0) ctrlReg <= {regWdata[15:3],
            ctrlReg[15] ? ctrlReg[2] : regWdata[2], regWdata[1:0]} & spa_pkg::CTRL_LOW_MASK;
    end
    always_ff @(posedge clk) prevReg <= resetn ? ctrlReg : 16'h0000;
    // cycles of select high, saturating
    always_ff @(posedge clk) selHiReg <= slaveSelectPinIn ? selHiReg + {2'h0, selHiReg != 3'h7} : 3'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ctrl_read_a: assert property ($past(regRead) && $past(regAddr) == 4'h0
        |-> regRdata == {16'h0, prevReg}) else $error("ctrl readback");
    off_pins_a: assert property (st && !ctrlReg[15] |-> serialOutPinOeN && shiftClockPinOeN)
        else $error("pins driven off");
    off_idle_a: assert property (st && !ctrlReg[15] |-> shiftClockPinOut == ctrlReg[6])
        else $error("clock not idle");
    slave_clk_a: assert property (on && !ctrlReg[5] |-> shiftClockPinOeN)
        else $error("slave drives clock");
    sel_tri_a: assert property (slv && ctrlReg[7] && selHiReg == 3'h7 |-> serialOutPinOeN)
        else $error("output not released");
    sel_ignore_a: assert property (slv && !ctrlReg[7] |-> !serialOutPinOeN)
        else $error("select not ignored");
    out_rel_a: assert property (st && ctrlReg[12] |-> serialOutPinOeN)
        else $error("released pin driven");
    idle_halt_a: assert property (on && ctrlReg[13] && cpuIdle && $past(cpuIdle)
        |-> $stable(serialOutPinOut) && $stable(shiftClockPinOut)) else $error("ran in idle");
endmodule // spa_serial_asserts
`default_nettype wire

// [bench/spa_link_master.sv]
// Purpose: serial master on the far side
// Assumes: clock idle low, bit time 800 ns
// Notes: input taken late in each bit
`timescale 1ns/1ps
`default_nettype none
module spa_link_master (
    output logic sck,
    output logic selN,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        selN = 1'b1;
        mosi = 1'b0;
    end
    // msb first, cut short after cut bits
    task automatic xfer(input int n, input int cut, input logic useSel,
        input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        #7 selN = !useSel;
        #400;
        for (int i = 0; i < cut; i++) begin
            mosi = tx[n - 1 - i];
            sck = 1'b1;
            #400 sck = 1'b0;
            #200 rx = {rx[30:0], miso};
            #200;
        end
        selN = 1'b1;
        // released line must not keep the last bit
        mosi = ~mosi;
        #800;
    endtask
endmodule // spa_link_master
`default_nettype wire

// [bench/testbench.sv]
// Purpose: slave-mode tests of the serial core
// Assumes: link master model on the far side
// Notes: standard buffer, clock idle low
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0, cpuIdle = 1'b0;
    logic refClk = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata, d, rv, rx, sse;
    logic sckOut, sckOeN, mSck, selN, mosi, sdo, sdoOeN;
    wire logic miso = sdoOeN ? 1'bz : sdo;
    int n_errors = 0, samples_checked = 0, cyc = 0, n;
    int seed = 32'h471a2336;
    spa_serial_core i_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .cpuIdle(cpuIdle),
        .referenceClockOut(refClk), .shiftClockPinIn(sckOeN ? mSck : sckOut),
        .shiftClockPinOut(sckOut), .shiftClockPinOeN(sckOeN), .serialInPin(mosi),
        .serialOutPinOut(sdo), .serialOutPinOeN(sdoOeN), .slaveSelectPinIn(selN),
        .channelClockOut(), .channelClockOeN());
    spa_link_master i_master (.sck(mSck), .selN(selN), .mosi(mosi), .miso(miso));
    always #50 clk = ~clk;
    always #370 refClk = ~refClk;
    function automatic logic [31:0] msk(input int w);
        return w == 32 ? 32'hffffffff : (32'h1 << w) - 32'h1;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrReg(input logic [3:0] a, input logic [31:0] v);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regRdata & m, exp, "register");
        @(posedge clk);
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rdChk(4'h0, 32'h0, 32'hffffffff);
        rdChk(4'h2, 32'h0, 32'hffffffff);
        wrReg(4'h0, 32'h8004);
        wrReg(4'h0, 32'h8000);
        rdChk(4'h0, 32'h8004, 32'hffff);
        for (int m = 0; m < 3; m++) begin
            n = 8 << m;
            sse = (m == 1) ? 32'h80 : 32'h0;
            wrReg(4'h0, sse | (m << 10));
            wrReg(4'h0, sse | (m << 10) | 32'h8000);
            d = $random(seed) & msk(n);
            wrReg(4'h8, d);
            repeat (4) @(posedge clk);
            rdChk(4'hc, sse[7] ? 32'h0 : 32'h8, 32'h8);
            if (sse[7]) begin
                i_master.xfer(n, 3, 1'b1, 32'h0, rx);
                @(posedge clk);
                rdChk(4'hc, 32'h0, 32'h8);
            end
            rv = $random(seed) & msk(n);
            i_master.xfer(n, n, sse[7], rv, rx);
            @(posedge clk);
            chk(rx, d, "word sent");
            rdChk(4'h8, rv, msk(n));
            rdChk(4'hc, 32'h8, 32'h8);
        end
        wrReg(4'h0, 32'hb000);
        cpuIdle <= 1'b1;
        repeat (8) @(posedge clk);
        cpuIdle <= 1'b0;
        finish_test();
    end
endmodule // testbench
bind spa_serial_core spa_serial_asserts i_chk (.*);
`default_nettype wire
